// ===== plo_aout_model.sv
// analog output module model latching each loop transfer
`timescale 1ns/100ps
`default_nettype none
module plo_aout_model
(
  input  wire logic        core_clk,
  input  wire logic [15:0] analog_out,
  input  wire logic        analog_out_valid,
  output logic      [15:0] chan_level
);
  initial chan_level = 16'h0000;
  // only core transfers write the channel: loop results, or the ladder-preset output word in manual
  always @(posedge core_clk)
    if (analog_out_valid)
      chan_level <= analog_out;
endmodule
`default_nettype wire

// ===== plo_core.sv
// one loop calculation core: error shaping, bcd gains, clamping and bias freeze
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - computed control output is stored at loop table word five.
// - computed output never exceeds upper limit; zero upper limit keeps it zero.
// - without auto transfer, analog output is not updated outside run state.
// - output coding unipolar or bipolar, 12 or 15 bits wide.
// - each gain is four-digit bcd 0000-9999, meaning 00.00-99.99.
// - output is sum of p, i, d terms, all fed the same error.
// - proportional code 0000 gives zero proportional contribution.
// - integral code 0000 or 9999 stops integrator updates; the stored bias still adds in.
// - integral gain in seconds or minutes; derivative in seconds.
// - derivative code 0000 removes the derivative contribution.
// - optional derivative limit 0 to 20 applied to derivative term.
// - error is setpoint minus process value each calculation, not readable.
// - squared error mode squares magnitude and keeps the sign.
// - deadband replaces small errors by zero, others pass unchanged.
// - bias freeze stops integral update while output is out of bounds.
// - bias freeze is enabled by bit 10 of mode word one.
// - freeze point is end of full data range, not user limits.
// - alarm categories have independent enables and status bits.
// - bit 15 clear forces manual outside run; set keeps loops running.
module plo_core
  import plo_pkg::*;
#(
  parameter int DATA_W = 16
)(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              sample_en,
  input  wire logic              cpu_run,
  input  wire logic              auto_mode,
  input  wire plo_pkg::plo_cfg_t cfg,
  input  wire plo_pkg::plo_gain_t gains,
  input  wire logic [4:0]        deriv_limit,
  input  wire logic [15:0]       deadband_size,
  input  wire logic [15:0]       setpoint_value,
  input  wire logic [15:0]       process_value,
  input  wire logic [15:0]       upper_limit,
  input  wire logic [15:0]       lower_limit,
  input  wire logic [15:0]       alarm_thresh,
  input  wire logic              tbl_we,
  input  wire logic [4:0]        tbl_addr,
  input  wire logic [15:0]       tbl_wdata,
  output logic      [15:0]       tbl_rdata,
  output logic      [15:0]       analog_out,
  output logic                   analog_out_valid,
  output logic                   loop_active,
  output logic                   dev_alarm,
  output logic                   roc_alarm
);
  import plo_pkg::*;

  // ---------------------------------------------------------------
  // loop table words
  // ---------------------------------------------------------------
  logic [15:0]        mode_one_reg;
  logic [15:0]        ctrl_out_reg;
  logic signed [31:0] bias_reg;
  logic signed [17:0] prev_err_reg;
  logic [15:0]        prev_pv_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      mode_one_reg <= MODE_ONE_RESET;
    else if (tbl_we && tbl_addr == OFF_MODE_ONE)
      mode_one_reg <= tbl_wdata;
  end

  always_comb
  begin
    if (tbl_addr == OFF_MODE_ONE)
      tbl_rdata = mode_one_reg;
    else if (tbl_addr == OFF_CTRL_OUT)
      tbl_rdata = ctrl_out_reg;
    else
      tbl_rdata = 16'h0000;
  end

  // ---------------------------------------------------------------
  // bcd decode
  // ---------------------------------------------------------------
  function automatic logic [13:0] bcd_to_bin(input logic [15:0] b);
    logic [13:0] r;
    r = 14'(b[15:12]) * 14'd1000 + 14'(b[11:8]) * 14'd100
      + 14'(b[7:4]) * 14'd10 + 14'(b[3:0]);
    return r;
  endfunction

  logic [13:0] kp;
  logic [13:0] ki;
  logic [13:0] kd;
  logic        ki_off;
  assign kp     = (gains.prop == BCD_ZERO) ? 14'd0 : bcd_to_bin(gains.prop);
  assign ki_off = (gains.integ == BCD_ZERO) || (gains.integ == BCD_ALL_NINES);
  assign ki     = ki_off ? 14'd0 : bcd_to_bin(gains.integ);
  assign kd     = (gains.deriv == BCD_ZERO) ? 14'd0 : bcd_to_bin(gains.deriv);

  // ---------------------------------------------------------------
  // error shaping
  // ---------------------------------------------------------------
  logic signed [17:0] err_raw;
  logic [16:0]        err_mag;
  logic [33:0]        err_sq;
  logic signed [17:0] err_shaped;
  logic signed [17:0] err_used;

  assign err_raw = $signed({2'b00, setpoint_value}) - $signed({2'b00, process_value});
  assign err_mag = err_raw[17] ? 17'(-err_raw) : 17'(err_raw);
  // scaling the square back by the data range keeps it in the same units as the error
  assign err_sq  = (34'(err_mag) * 34'(err_mag)) >> (cfg.fmt15 ? 15 : 12);

  always_comb
  begin
    err_shaped = err_raw;
    if (cfg.err_squared)
    begin
      if (err_sq > 34'h1FFFF)
        err_shaped = err_raw[17] ? -18'sh1FFFF : 18'sh1FFFF;
      else
        err_shaped = err_raw[17] ? -$signed({1'b0, err_sq[16:0]})
                                 : $signed({1'b0, err_sq[16:0]});
    end
  end

  assign err_used = (cfg.deadband_en && err_mag <= 17'(deadband_size))
                    ? 18'sd0 : err_shaped;

  // ---------------------------------------------------------------
  // p, i, d terms in hundredths of a count
  // ---------------------------------------------------------------
  logic signed [31:0] p_term;
  logic signed [31:0] i_step;
  logic signed [31:0] d_raw;
  logic signed [31:0] d_term;
  logic signed [31:0] d_cap;
  logic signed [31:0] sum;
  logic signed [31:0] out_pct;
  logic signed [31:0] full_hi;
  logic signed [31:0] full_lo;
  logic signed [31:0] clamped;
  logic               out_of_bounds;

  assign p_term = 32'(err_used) * $signed({18'd0, kp});
  // integral gain acts as a rate in repeats per time unit; minutes divide it down
  assign i_step = cfg.int_minutes
                  ? (32'(err_used) * $signed({18'd0, ki})) / MIN_PER_SEC
                  : 32'(err_used) * $signed({18'd0, ki});
  assign d_raw  = 32'(err_used - prev_err_reg) * $signed({18'd0, kd});
  assign d_cap  = 32'(p_term) * $signed({27'd0, deriv_limit});
  always_comb
  begin
    d_term = d_raw;
    if (cfg.dlim_en && deriv_limit <= DLIM_MAX)
    begin
      // limit scales with proportional action, so it shrinks the kick on noise
      if (d_raw > (d_cap < 0 ? -d_cap : d_cap))
        d_term = (d_cap < 0 ? -d_cap : d_cap);
      else if (d_raw < -(d_cap < 0 ? -d_cap : d_cap))
        d_term = -(d_cap < 0 ? -d_cap : d_cap);
    end
  end

  assign sum     = p_term + bias_reg + d_term;
  assign out_pct = sum / GAIN_SCALE;

  // full data range of the selected coding
  always_comb
  begin
    full_hi = cfg.fmt15 ? 32'(RANGE_U15) : 32'(RANGE_U12);
    full_lo = 32'sd0;
    if (cfg.bipolar)
    begin
      full_hi = cfg.fmt15 ? 32'sd16383 : 32'sd2047;
      full_lo = cfg.fmt15 ? -32'sd16384 : -32'sd2048;
    end
  end

  assign out_of_bounds = (out_pct >= full_hi) || (out_pct <= full_lo);

  always_comb
  begin
    clamped = out_pct;
    if (clamped > $signed({16'd0, upper_limit}))
      clamped = $signed({16'd0, upper_limit});
    if (clamped < $signed({16'd0, lower_limit}))
      clamped = $signed({16'd0, lower_limit});
    if (clamped > $signed({16'd0, upper_limit}))
      clamped = $signed({16'd0, upper_limit});
  end

  // ---------------------------------------------------------------
  // mode handling
  // ---------------------------------------------------------------
  assign loop_active = auto_mode && (cpu_run || mode_one_reg[BIT_INDEPENDENT]);

  logic calc;
  assign calc = sample_en && loop_active;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      bias_reg <= 32'sd0;
    else if (calc && !(mode_one_reg[BIT_FREEZE_BIAS] && out_of_bounds))
      bias_reg <= bias_reg + i_step;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      prev_err_reg <= 18'sd0;
      prev_pv_reg  <= 16'h0000;
    end
    else if (calc)
    begin
      prev_err_reg <= err_used;
      prev_pv_reg  <= process_value;
    end
  end

  // ladder writes may preset the output word in manual mode
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ctrl_out_reg <= CTRL_OUT_RESET;
    else if (calc)
      ctrl_out_reg <= clamped[15:0];
    else if (tbl_we && tbl_addr == OFF_CTRL_OUT)
      ctrl_out_reg <= tbl_wdata;
  end

  // ---------------------------------------------------------------
  // analog output transfer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      analog_out       <= 16'h0000;
      analog_out_valid <= 1'b0;
    end
    else
    begin
      analog_out_valid <= 1'b0;
      if (sample_en && (cfg.auto_xfer ? loop_active : cpu_run))
      begin
        analog_out       <= calc ? clamped[15:0] : ctrl_out_reg;
        analog_out_valid <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // independent alarm categories
  // ---------------------------------------------------------------
  logic [15:0] pv_delta;
  assign pv_delta = (process_value > prev_pv_reg) ? process_value - prev_pv_reg
                                                  : prev_pv_reg - process_value;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dev_alarm <= 1'b0;
      roc_alarm <= 1'b0;
    end
    else if (calc)
    begin
      dev_alarm <= mode_one_reg[BIT_DEV_ALARM] && (err_mag > 17'(alarm_thresh));
      roc_alarm <= mode_one_reg[BIT_ROC_ALARM] && (pv_delta > alarm_thresh);
    end
  end
endmodule
`default_nettype wire

// ===== plo_core_props.sv
// port-level checker for the loop core
`timescale 1ns/100ps
`default_nettype none
module plo_core_props
  import plo_pkg::*;
#(
  parameter int DATA_W = 16
)(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              sample_en,
  input wire logic              cpu_run,
  input wire logic              auto_mode,
  input wire plo_pkg::plo_cfg_t cfg,
  input wire logic [15:0]       upper_limit,
  input wire logic [15:0]       lower_limit,
  input wire logic              tbl_we,
  input wire logic [4:0]        tbl_addr,
  input wire logic [15:0]       tbl_wdata,
  input wire logic [15:0]       tbl_rdata,
  input wire logic [15:0]       analog_out,
  input wire logic              analog_out_valid,
  input wire logic              loop_active,
  input wire logic              dev_alarm,
  input wire logic              roc_alarm
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic calc;
  wire logic at_out;
  assign calc = sample_en && loop_active;
  assign at_out = tbl_addr == OFF_CTRL_OUT;
  upper_bound_a:
    assert property (calc |=> !at_out || tbl_rdata <= $past(upper_limit))
    else $error("control output above upper limit");
  lower_bound_a:
    assert property (calc |=> !at_out || $past(lower_limit) > $past(upper_limit)
      || tbl_rdata >= $past(lower_limit)) else $error("control output below lower limit");
  halt_hold_a:
    assert property (!cpu_run && !cfg.auto_xfer |=> !analog_out_valid)
    else $error("analog output moved outside run");
  run_xfer_a:
    assert property (calc && cpu_run |=> analog_out_valid) else $error("no transfer after calc");
  manual_idle_a:
    assert property (!auto_mode |-> !loop_active) else $error("manual loop is active");
  run_active_a:
    assert property (auto_mode && cpu_run |-> loop_active) else $error("run loop inactive");
  out_stands_a:
    assert property (!analog_out_valid |-> $stable(analog_out))
    else $error("analog output changed without transfer");
  mode_write_a:
    assert property (tbl_we && tbl_addr == OFF_MODE_ONE |=> tbl_addr != OFF_MODE_ONE
      || tbl_rdata == $past(tbl_wdata)) else $error("mode word write lost");
  unmapped_zero_a:
    assert property (tbl_addr != OFF_MODE_ONE && !at_out |-> tbl_rdata == 16'h0000)
    else $error("unmapped word reads nonzero");
  alarm_stands_a:
    assert property (!$past(calc) |-> $stable({dev_alarm, roc_alarm}))
    else $error("alarm changed without calc");
  cover property (calc ##1 analog_out_valid);
  cover property (calc && !cpu_run);
  cover property (tbl_we && tbl_addr == OFF_MODE_ONE);
endmodule
bind plo_core plo_core_props #(.DATA_W(DATA_W)) u_plo_core_props (.*);
`default_nettype wire

// ===== plo_pkg.sv
// package of constants, types and layouts for the loop output and tuning core
package plo_pkg;
  // ---------------------------------------------------------------
  // loop table word offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_MODE_ONE   = 5'h00;
  localparam logic [4:0] OFF_CTRL_OUT   = 5'h05;
  // ---------------------------------------------------------------
  // first mode setting word fields and reset values
  // ---------------------------------------------------------------
  localparam int         BIT_FREEZE_BIAS = 10;
  localparam int         BIT_DEV_ALARM   = 13;
  localparam int         BIT_ROC_ALARM   = 14;
  localparam int         BIT_INDEPENDENT = 15;
  localparam logic [15:0] MODE_ONE_RESET = 16'h0000;
  localparam logic [15:0] CTRL_OUT_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // numeric limits
  // ---------------------------------------------------------------
  localparam logic [15:0] BCD_ZERO       = 16'h0000;
  localparam logic [15:0] BCD_ALL_NINES  = 16'h9999;
  localparam logic [4:0]  DLIM_MAX       = 5'h14;
  localparam logic [15:0] RANGE_U12      = 16'h0FFF;
  localparam logic [15:0] RANGE_U15      = 16'h7FFF;
  localparam int          GAIN_SCALE     = 100;
  localparam int          MIN_PER_SEC    = 60;

  typedef struct packed {
    logic        err_squared;
    logic        deadband_en;
    logic        dlim_en;
    logic        int_minutes;
    logic        bipolar;
    logic        fmt15;
    logic        auto_xfer;
  } plo_cfg_t;

  typedef struct packed {
    logic [15:0] prop;
    logic [15:0] integ;
    logic [15:0] deriv;
  } plo_gain_t;
endpackage

// ===== tb.sv
// self-checking bench for the loop core
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t %s got %h", $time, m, g); end end
module tb;
  import plo_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, sample_en = 1'b0, cpu_run = 1'b1;
  logic auto_mode = 1'b1, tbl_we = 1'b0, vld, analog_out_valid, loop_active, dev_alarm, roc_alarm;
  plo_cfg_t cfg = '0;
  plo_gain_t gains = '0;
  logic [4:0] tbl_addr = 5'h00;
  logic [15:0] sp = 16'h0000, pv = 16'h0000, upper = 16'h0FFF, lower = 16'h0000, db = 16'h0000;
  logic [15:0] tbl_wdata = 16'h0000, tbl_rdata, analog_out, chan_level, o;
  logic [4:0] dlim = 5'h00;
  logic [15:0] thr = 16'h0100;
  int err_total = 0, total_checks = 0;
  always #2.5 core_clk = ~core_clk;
  plo_core u_plo_core (.core_clk(core_clk), .rst_n(rst_n), .sample_en(sample_en),
    .cpu_run(cpu_run), .auto_mode(auto_mode), .cfg(cfg), .gains(gains),
    .deriv_limit(dlim), .deadband_size(db), .setpoint_value(sp), .process_value(pv),
    .upper_limit(upper), .lower_limit(lower), .alarm_thresh(thr), .tbl_we(tbl_we),
    .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata),
    .analog_out(analog_out), .analog_out_valid(analog_out_valid),
    .loop_active(loop_active), .dev_alarm(dev_alarm), .roc_alarm(roc_alarm));
  plo_aout_model u_plo_aout_model (.core_clk(core_clk), .analog_out(analog_out),
    .analog_out_valid(analog_out_valid), .chan_level(chan_level));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic rd(input logic [4:0] a);
    @(negedge core_clk);
    tbl_addr = a;
    #1 o = tbl_rdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    {tbl_addr, tbl_wdata, tbl_we} = {a, d, 1'b1};
    @(negedge core_clk);
    tbl_we = 1'b0;
  endtask
  // one sample pulse; result stands from the next edge
  task automatic run(input logic [15:0] p, i, s, v);
    @(negedge core_clk);
    {gains.prop, gains.integ, sp, pv, sample_en} = {p, i, s, v, 1'b1};
    @(negedge core_clk);
    sample_en = 1'b0;
    tbl_addr = OFF_CTRL_OUT;
    #1 o = tbl_rdata;
    vld = analog_out_valid;
  endtask
  task automatic t_regs;
    rd(OFF_MODE_ONE); `CHK(o, MODE_ONE_RESET, "mode reset")
    rd(OFF_CTRL_OUT); `CHK(o, CTRL_OUT_RESET, "out reset")
    wr(OFF_MODE_ONE, 16'h8400); rd(OFF_MODE_ONE); `CHK(o, 16'h8400, "mode rw")
    wr(5'h03, 16'hFFFF); rd(5'h03); `CHK(o, 16'h0000, "unmapped")
    wr(OFF_MODE_ONE, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_gains;
    lower = 16'h0100;
    run(16'h0000, 16'h0000, 16'h0800, 16'h0000); `CHK(o, 16'h0100, "no terms")
    run(16'h0000, 16'h9999, 16'h0800, 16'h0000); `CHK(o, 16'h0100, "infinite i")
    lower = 16'h0000;
    run(16'h0100, 16'h0000, 16'h0800, 16'h0000); `CHK(o, 16'h0800, "unit p")
    run(16'h0050, 16'h0000, 16'h0800, 16'h0000); `CHK(o, 16'h0400, "half p")
    run(16'h9999, 16'h0000, 16'h0001, 16'h0000); `CHK(o, 16'h0063, "max p")
    upper = 16'h0000;
    run(16'h0100, 16'h0000, 16'h0800, 16'h0000); `CHK(o, 16'h0000, "zero upper")
    upper = 16'h0FFF;
    $display("test gains done");
  endtask
  task automatic t_shape;
    {cfg.deadband_en, db} = {1'b1, 16'h0010};
    run(16'h0100, 16'h0000, 16'h0808, 16'h0800); `CHK(o, 16'h0000, "in band")
    run(16'h0100, 16'h0000, 16'h0820, 16'h0800); `CHK(o, 16'h0020, "out band")
    {cfg.deadband_en, cfg.err_squared} = 2'b01;
    run(16'h0100, 16'h0000, 16'h0800, 16'h0000); `CHK(o, 16'h0400, "squared")
    cfg.err_squared = 1'b0;
    $display("test shape done");
  endtask
  task automatic t_run;
    @(negedge core_clk);
    cpu_run = 1'b0;
    #1 `CHK(loop_active, 1'b0, "follow cpu")
    wr(OFF_MODE_ONE, 16'h8000); `CHK(loop_active, 1'b1, "independent")
    run(16'h0100, 16'h0000, 16'h0123, 16'h0000); `CHK(vld, 1'b0, "halted xfer")
    cfg.auto_xfer = 1'b1;
    run(16'h0100, 16'h0000, 16'h0123, 16'h0000); `CHK(vld, 1'b1, "auto xfer")
    @(posedge core_clk);
    #1 `CHK(chan_level, 16'h0123, "module level")
    @(negedge core_clk);
    cpu_run = 1'b1;
    $display("test run done");
  endtask
  // bias accumulates across calls, so the order of these runs matters
  task automatic t_terms;
    run(16'h0000, 16'h0100, 16'h0100, 16'h0000); `CHK(o, 16'h0000, "i first")
    run(16'h0000, 16'h0100, 16'h0100, 16'h0000); `CHK(o, 16'h0100, "i second")
    wr(OFF_MODE_ONE, 16'h8400);
    run(16'h0200, 16'h0100, 16'h0FFF, 16'h0000); `CHK(o, 16'h0FFF, "sat high")
    run(16'h0000, 16'h0100, 16'h0000, 16'h0000); `CHK(o, 16'h0200, "bias frozen")
    upper = 16'h0100;
    run(16'h0000, 16'h0100, 16'h0100, 16'h0000); `CHK(o, 16'h0100, "user clamp")
    upper = 16'h0FFF;
    run(16'h0000, 16'h0000, 16'h0000, 16'h0000); `CHK(o, 16'h0300, "no user freeze")
    cfg.int_minutes = 1'b1;
    run(16'h0000, 16'h0100, 16'h003C, 16'h0000); `CHK(o, 16'h0300, "min step")
    cfg.int_minutes = 1'b0;
    run(16'h0000, 16'h0000, 16'h0000, 16'h0000); `CHK(o, 16'h0301, "minutes")
    gains.deriv = 16'h0100;
    run(16'h0000, 16'h0000, 16'h0100, 16'h0000); `CHK(o, 16'h0401, "deriv")
    {cfg.dlim_en, dlim} = {1'b1, 5'h01};
    run(16'h0000, 16'h0000, 16'h0200, 16'h0000); `CHK(o, 16'h0301, "deriv limit")
    {cfg.dlim_en, gains.deriv} = {1'b0, 16'h0000};
    {cfg.fmt15, cfg.err_squared} = 2'b11;
    run(16'h0100, 16'h0000, 16'h0800, 16'h0000); `CHK(o, 16'h0381, "sq 15 bit")
    {cfg.fmt15, cfg.err_squared} = 2'b00;
    $display("test terms done");
  endtask
  task automatic t_alarm;
    wr(OFF_MODE_ONE, 16'hA400);
    run(16'h0000, 16'h0000, 16'h0200, 16'h0000); `CHK(dev_alarm, 1'b1, "dev on")
    `CHK(roc_alarm, 1'b0, "roc off")
    wr(OFF_MODE_ONE, 16'hC400);
    run(16'h0000, 16'h0000, 16'h0200, 16'h0200); `CHK(roc_alarm, 1'b1, "roc on")
    `CHK(dev_alarm, 1'b0, "dev off")
    $display("test alarm done");
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    t_regs();
    t_gains();
    t_shape();
    t_run();
    t_terms();
    t_alarm();
    report_and_stop();
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    $display("mismatch t=%0t run timed out", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
